// *** common/dss_regs.vh ***
`ifndef DSS_REGS_VH
`define DSS_REGS_VH

// Register word addresses on the plain register port
`define DSS_OFF_STATUS   4'h0
`define DSS_OFF_MASK     4'h1
`define DSS_OFF_L1_NA    4'h2
`define DSS_OFF_L1_REF   4'h3
`define DSS_OFF_L2_NA    4'h4
`define DSS_OFF_L2_REF   4'h5
`define DSS_OFF_PINS     4'h6

// Status and mask layout
`define DSS_ST_LOAD_L1   0
`define DSS_ST_LOAD_L2   1
`define DSS_ST_LOST_L1   2
`define DSS_ST_LOST_L2   3
`define DSS_ST_W         4

// Shift register layout, last bit shifted sits at bit 0
`define DSS_SR_W         24
`define DSS_SR_LOOP      0
`define DSS_SR_SW        1
`define DSS_SR_CTRL      2
`define DSS_SR_A_LSB     3
`define DSS_SR_A_MSB     9
`define DSS_SR_N_LSB     10
`define DSS_SR_N_MSB     19
`define DSS_SR_R_LSB     3
`define DSS_SR_R_MSB     16

// Counter widths
`define DSS_R_W          14
`define DSS_N_W          10
`define DSS_A_W          7

// Latch and mask register reset values
`define DSS_RST_R        14'h0008
`define DSS_RST_N        10'h008
`define DSS_RST_A        7'h00
`define DSS_RST_SW       1'b1
`define DSS_RST_MASK     4'h0

`endif

// *** hw/dss_core.v ***
// Contract
// - Shift serial data on each serial clock rise
// - Last bit picks loop one or two
// - Second-last bit sets switch low or released
// - Third-last bit picks divider or reference latch
// - Strobe pulse copies shift register into latches
// - Shifting alone never alters latches or counters
// - VCO edge decrements main and active swallow
// - Phase output low leading, high lagging, else float
// - Modulus low until swallow done, then high
// - Lock indicator high locked, low pulses otherwise
`include "dss_regs.vh"
`timescale 1ns/1ps
`default_nettype none

module dss_core (
	input  wire        clk_sys,
	input  wire        rst_n,
	input  wire        ser_clk,
	input  wire        ser_data,
	input  wire        latch_load_strobe,
	input  wire        vco_in_loop1,
	input  wire        vco_in_loop2,
	input  wire        ref_osc_input,
	output wire        ref_osc_output,
	output wire        prescaler_sel_loop1,
	output wire        prescaler_sel_loop2,
	output wire        lock_ind_loop1,
	output wire        lock_ind_loop2,
	output wire        phase_err_out_loop1,
	output wire        phase_err_oe_loop1,
	output wire        phase_err_out_loop2,
	output wire        phase_err_oe_loop2,
	output wire        od_switch_loop1,
	output wire        od_switch_oe_loop1,
	output wire        od_switch_loop2,
	output wire        od_switch_oe_loop2,
	input  wire [3:0]  reg_addr,
	input  wire [31:0] reg_wdata,
	input  wire        reg_wr,
	input  wire        reg_rd,
	output wire [31:0] reg_rdata,
	output wire        irq
);

	// Two-stage synchronisers: {osc, strobe, data, sclk}
	reg  [3:0]              sync1_ff;
	reg  [3:0]              sync2_ff;
	reg  [3:0]              sync3_ff;
	reg  [`DSS_SR_W-1:0]    sr_ff;
	reg  [`DSS_ST_W-1:0]    status_ff;
	reg  [`DSS_ST_W-1:0]    mask_ff;
	reg  [31:0]             rdata_ff;
	reg                     osc_out_ff;
	reg  [31:0]             nxt_rdata;
	reg  [`DSS_ST_W-1:0]    nxt_status;
	wire                    sclk_rise;
	wire                    ld_rise;
	wire                    osc_rise;
	wire [1:0]              vco_pin;
	wire [1:0]              ld_ev;
	wire [1:0]              lost_ev;

	assign sclk_rise = sync2_ff[0] & ~sync3_ff[0];
	assign ld_rise   = sync2_ff[2] & ~sync3_ff[2];
	assign osc_rise  = sync2_ff[3] & ~sync3_ff[3];
	assign vco_pin   = {vco_in_loop2, vco_in_loop1};

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sync1_ff   <= 4'h0;
			sync2_ff   <= 4'h0;
			sync3_ff   <= 4'h0;
			osc_out_ff <= 1'b1;
		end else begin
			sync1_ff   <= {ref_osc_input, latch_load_strobe, ser_data,
				ser_clk};
			sync2_ff   <= sync1_ff;
			sync3_ff   <= sync2_ff;
			// Inverted copy of the oscillator, as the on-chip amplifier gives
			osc_out_ff <= ~sync2_ff[3];
		end
	end

	// Shift register; data and clock pass the same synchroniser depth, so
	// the sampled bit is the one that stood at the serial clock rise
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sr_ff <= {`DSS_SR_W{1'b0}};
		end else if (sclk_rise) begin
			sr_ff <= {sr_ff[`DSS_SR_W-2:0], sync2_ff[1]};
		end
	end

	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : lp
			reg  [1:0]            vs_ff;
			reg                   vs3_ff;
			reg  [`DSS_R_W-1:0]   r_lat_ff;
			reg  [`DSS_R_W-1:0]   r_cnt_ff;
			reg  [`DSS_N_W-1:0]   n_lat_ff;
			reg  [`DSS_N_W-1:0]   n_cnt_ff;
			reg  [`DSS_A_W-1:0]   a_lat_ff;
			reg  [`DSS_A_W-1:0]   a_cnt_ff;
			reg                   sw_ff;
			reg                   mc_ff;
			reg                   ref_ev_ff;
			reg                   vco_ev_ff;
			reg                   up_ff;
			reg                   dn_ff;
			reg                   lock_ff;
			reg                   pd_out_ff;
			reg                   pd_oe_ff;
			reg                   ld_ev_ff;
			wire                  vco_rise;
			wire                  sel;

			assign vco_rise = vs_ff[1] & ~vs3_ff;
			// Loop 1 answers a one in the last bit, loop 2 a zero
			assign sel = ld_rise & (sr_ff[`DSS_SR_LOOP] == (g == 0));

			always @(posedge clk_sys or negedge rst_n) begin
				if (!rst_n) begin
					vs_ff  <= 2'b00;
					vs3_ff <= 1'b0;
				end else begin
					vs_ff  <= {vs_ff[0], vco_pin[g]};
					vs3_ff <= vs_ff[1];
				end
			end

			// Latches move only on a strobe rise, never while shifting
			always @(posedge clk_sys or negedge rst_n) begin
				if (!rst_n) begin
					r_lat_ff <= `DSS_RST_R;
					n_lat_ff <= `DSS_RST_N;
					a_lat_ff <= `DSS_RST_A;
					sw_ff    <= `DSS_RST_SW;
					ld_ev_ff <= 1'b0;
				end else begin
					ld_ev_ff <= sel;
					if (sel) begin
						sw_ff <= sr_ff[`DSS_SR_SW];
						if (sr_ff[`DSS_SR_CTRL]) begin
							r_lat_ff <= sr_ff[`DSS_SR_R_MSB:`DSS_SR_R_LSB];
						end else begin
							n_lat_ff <= sr_ff[`DSS_SR_N_MSB:`DSS_SR_N_LSB];
							a_lat_ff <= sr_ff[`DSS_SR_A_MSB:`DSS_SR_A_LSB];
						end
					end
				end
			end

			// Reference divider; a new value takes effect at the next reload
			always @(posedge clk_sys or negedge rst_n) begin
				if (!rst_n) begin
					r_cnt_ff  <= `DSS_RST_R;
					ref_ev_ff <= 1'b0;
				end else begin
					ref_ev_ff <= 1'b0;
					if (osc_rise) begin
						if (r_cnt_ff <= {{(`DSS_R_W-1){1'b0}}, 1'b1}) begin
							r_cnt_ff  <= r_lat_ff;
							ref_ev_ff <= 1'b1;
						end else begin
							r_cnt_ff <= r_cnt_ff - 1'b1;
						end
					end
				end
			end

			// Main and swallow counters with modulus control
			always @(posedge clk_sys or negedge rst_n) begin
				if (!rst_n) begin
					n_cnt_ff  <= `DSS_RST_N;
					a_cnt_ff  <= `DSS_RST_A;
					mc_ff     <= 1'b0;
					vco_ev_ff <= 1'b0;
				end else begin
					vco_ev_ff <= 1'b0;
					if (vco_rise) begin
						if (n_cnt_ff <= {{(`DSS_N_W-1){1'b0}}, 1'b1}) begin
							n_cnt_ff  <= n_lat_ff;
							a_cnt_ff  <= a_lat_ff;
							mc_ff     <= (a_lat_ff == `DSS_RST_A);
							vco_ev_ff <= 1'b1;
						end else begin
							n_cnt_ff <= n_cnt_ff - 1'b1;
							if (a_cnt_ff != `DSS_RST_A) begin
								a_cnt_ff <= a_cnt_ff - 1'b1;
								mc_ff    <= (a_cnt_ff == 7'h01);
							end
						end
					end
				end
			end

			// Three-state detector: up pumps high, down pumps low
			always @(posedge clk_sys or negedge rst_n) begin
				if (!rst_n) begin
					up_ff     <= 1'b0;
					dn_ff     <= 1'b0;
					lock_ff   <= 1'b1;
					pd_out_ff <= 1'b0;
					pd_oe_ff  <= 1'b0;
				end else begin
					if ((up_ff | ref_ev_ff) & (dn_ff | vco_ev_ff)) begin
						up_ff <= 1'b0;
						dn_ff <= 1'b0;
					end else begin
						up_ff <= up_ff | ref_ev_ff;
						dn_ff <= dn_ff | vco_ev_ff;
					end
					pd_out_ff <= up_ff;
					pd_oe_ff  <= up_ff ^ dn_ff;
					lock_ff   <= ~(up_ff ^ dn_ff);
				end
			end

			assign ld_ev[g]   = ld_ev_ff;
			assign lost_ev[g] = lock_ff & (up_ff ^ dn_ff);
		end
	endgenerate

	assign ref_osc_output      = osc_out_ff;
	assign prescaler_sel_loop1 = lp[0].mc_ff;
	assign prescaler_sel_loop2 = lp[1].mc_ff;
	assign lock_ind_loop1      = lp[0].lock_ff;
	assign lock_ind_loop2      = lp[1].lock_ff;
	assign phase_err_out_loop1 = lp[0].pd_out_ff;
	assign phase_err_oe_loop1  = lp[0].pd_oe_ff;
	assign phase_err_out_loop2 = lp[1].pd_out_ff;
	assign phase_err_oe_loop2  = lp[1].pd_oe_ff;
	// Open drain: only ever pulls low
	assign od_switch_loop1     = 1'b0;
	assign od_switch_oe_loop1  = ~lp[0].sw_ff;
	assign od_switch_loop2     = 1'b0;
	assign od_switch_oe_loop2  = ~lp[1].sw_ff;

	// Sticky status; an event in the clearing cycle survives the clear
	always @* begin
		nxt_status = status_ff;
		if (reg_wr && reg_addr == `DSS_OFF_STATUS)
			nxt_status = status_ff & ~reg_wdata[`DSS_ST_W-1:0];
		nxt_status = nxt_status | {lost_ev, ld_ev};
	end

	always @* begin
		nxt_rdata = 32'h0000_0000;
		case (reg_addr)
		`DSS_OFF_STATUS: nxt_rdata[`DSS_ST_W-1:0] = status_ff;
		`DSS_OFF_MASK:   nxt_rdata[`DSS_ST_W-1:0] = mask_ff;
		`DSS_OFF_L1_NA:  nxt_rdata[16:0] = {lp[0].n_lat_ff, lp[0].a_lat_ff};
		`DSS_OFF_L1_REF: nxt_rdata[13:0] = lp[0].r_lat_ff;
		`DSS_OFF_L2_NA:  nxt_rdata[16:0] = {lp[1].n_lat_ff, lp[1].a_lat_ff};
		`DSS_OFF_L2_REF: nxt_rdata[13:0] = lp[1].r_lat_ff;
		`DSS_OFF_PINS:   nxt_rdata[5:0] = {lp[1].lock_ff, lp[0].lock_ff,
			lp[1].mc_ff, lp[0].mc_ff, lp[1].sw_ff, lp[0].sw_ff};
		default:         nxt_rdata = 32'h0000_0000;
		endcase
	end

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			status_ff <= {`DSS_ST_W{1'b0}};
			mask_ff   <= `DSS_RST_MASK;
			rdata_ff  <= 32'h0000_0000;
		end else begin
			status_ff <= nxt_status;
			if (reg_wr && reg_addr == `DSS_OFF_MASK)
				mask_ff <= reg_wdata[`DSS_ST_W-1:0];
			rdata_ff <= reg_rd ? nxt_rdata : 32'h0000_0000;
		end
	end

	assign reg_rdata = rdata_ff;
	assign irq       = |(status_ff & mask_ff);

endmodule

`default_nettype wire

// *** bench/dss_core_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module dss_core_checker (
	input wire logic        clk_sys,
	input wire logic        rst_n,
	input wire logic        latch_load_strobe,
	input wire logic        vco_in_loop1,
	input wire logic        prescaler_sel_loop1,
	input wire logic        lock_ind_loop1,
	input wire logic        lock_ind_loop2,
	input wire logic        phase_err_oe_loop1,
	input wire logic        phase_err_oe_loop2,
	input wire logic        od_switch_loop1,
	input wire logic        od_switch_loop2,
	input wire logic        od_switch_oe_loop1,
	input wire logic        od_switch_oe_loop2,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic        ref_osc_input,
	input wire logic        ref_osc_output
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// Long enough to cover the strobe and input pipelines
	sequence strobe_quiet; (!latch_load_strobe)[*8]; endsequence
	sequence vco_quiet; $stable(vco_in_loop1)[*8]; endsequence
	// A rise needs two sync stages and the output flop to show inverted
	sequence osc_rise; $rose(ref_osc_input); endsequence
	chk_osc_inverted: assert property (osc_rise |-> ##3 $fell(ref_osc_output))
		else $error("oscillator output not inverted");
	chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
		else $error("read data not idle");
	chk_sw1_open_drain: assert property (od_switch_loop1 == 1'b0)
		else $error("switch 1 drives high");
	chk_sw2_open_drain: assert property (od_switch_loop2 == 1'b0)
		else $error("switch 2 drives high");
	chk_sw1_hold: assert property (
		strobe_quiet |-> $stable(od_switch_oe_loop1))
		else $error("switch 1 moved without strobe");
	chk_sw2_hold: assert property (
		strobe_quiet |-> $stable(od_switch_oe_loop2))
		else $error("switch 2 moved without strobe");
	chk_lock1_detector: assert property (
		lock_ind_loop1 == !phase_err_oe_loop1)
		else $error("lock 1 disagrees with detector");
	chk_lock2_detector: assert property (
		lock_ind_loop2 == !phase_err_oe_loop2)
		else $error("lock 2 disagrees with detector");
	chk_mc1_idle: assert property (
		vco_quiet |-> $stable(prescaler_sel_loop1))
		else $error("modulus moved without vco edge");
endmodule
bind dss_core dss_core_checker u_chk (.clk_sys(clk_sys), .rst_n(rst_n),
	.latch_load_strobe(latch_load_strobe), .vco_in_loop1(vco_in_loop1),
	.prescaler_sel_loop1(prescaler_sel_loop1), .lock_ind_loop1(lock_ind_loop1),
	.lock_ind_loop2(lock_ind_loop2), .phase_err_oe_loop1(phase_err_oe_loop1),
	.phase_err_oe_loop2(phase_err_oe_loop2), .od_switch_loop1(od_switch_loop1),
	.od_switch_loop2(od_switch_loop2), .od_switch_oe_loop1(od_switch_oe_loop1),
	.od_switch_oe_loop2(od_switch_oe_loop2), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .ref_osc_input(ref_osc_input),
	.ref_osc_output(ref_osc_output));
`default_nettype wire

// *** bench/dss_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module dss_host (
	input  wire logic clk_sys,
	output var logic  ser_clk,
	output var logic  ser_data,
	output var logic  latch_load_strobe
);
	initial begin
		ser_clk = 1'b0;
		ser_data = 1'b0;
		latch_load_strobe = 1'b0;
	end
	// Serial clock rests low between frames; data flips so no stale bit lingers
	task automatic send(input logic [23:0] w, input int n, input bit ld);
		for (int i = n - 1; i >= 0; i--) begin
			ser_data <= w[i];
			repeat (16) @(posedge clk_sys);
			ser_clk <= 1'b1;
			repeat (16) @(posedge clk_sys);
			ser_clk <= 1'b0;
		end
		ser_data <= ~ser_data;
		repeat (8) @(posedge clk_sys);
		latch_load_strobe <= ld;
		repeat (8) @(posedge clk_sys);
		latch_load_strobe <= 1'b0;
		repeat (16) @(posedge clk_sys);
	endtask
endmodule
`default_nettype wire

// *** bench/dss_core_tb.sv ***
`include "dss_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module dss_core_tb;
	logic        clk_sys, rst_n, vco1, vco2, osc, wr, rd;
	logic [3:0]  addr, oc;
	logic [31:0] wdata, d;
	wire  [31:0] rdata;
	wire         sclk, sdat, stb, mc1, oe_sw1, oe_sw2, pd2, oe_pd2, lock2, irq;
	wire         mc2;
	int          fail_count, samples_checked, hi, k;

	dss_host u_dss_host (.clk_sys(clk_sys), .ser_clk(sclk), .ser_data(sdat),
		.latch_load_strobe(stb));
	dss_core u_dss_core (.clk_sys(clk_sys), .rst_n(rst_n), .ser_clk(sclk),
		.ser_data(sdat), .latch_load_strobe(stb), .vco_in_loop1(vco1),
		.vco_in_loop2(vco2), .ref_osc_input(osc), .ref_osc_output(),
		.prescaler_sel_loop1(mc1), .prescaler_sel_loop2(mc2),
		.lock_ind_loop1(), .lock_ind_loop2(lock2),
		.phase_err_out_loop1(), .phase_err_oe_loop1(),
		.phase_err_out_loop2(pd2), .phase_err_oe_loop2(oe_pd2),
		.od_switch_loop1(), .od_switch_oe_loop1(oe_sw1),
		.od_switch_loop2(), .od_switch_oe_loop2(oe_sw2),
		.reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd),
		.reg_rdata(rdata), .irq(irq));

	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	// Reference runs free so both detectors always see events
	always @(posedge clk_sys) begin
		oc <= (oc == 4'h5) ? 4'h0 : oc + 4'h1;
		if (oc == 4'h5) osc <= ~osc;
	end

	task automatic chk_word(input string nm, input logic [31:0] e, g);
		samples_checked++;
		if (g !== e) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk_bit(input string nm, input logic e, g);
		chk_word(nm, {31'h0, e}, {31'h0, g});
	endtask
	task automatic wreg(input logic [3:0] a, input logic [31:0] v);
		@(posedge clk_sys);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk_sys);
		wr <= 1'b0;
	endtask
	task automatic rreg(input logic [3:0] a);
		@(posedge clk_sys);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_sys);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic t_load;
		rreg(`DSS_OFF_L2_NA);
		chk_word("l2 na reset", 32'h400, d);
		rreg(4'h7);
		chk_word("unmapped", 32'h0, d);
		u_dss_host.send({4'h0, 10'h00a, 7'h03, 3'b001}, 20, 1'b1);
		rreg(`DSS_OFF_L1_NA);
		chk_word("l1 na", 32'h503, d);
		chk_bit("sw1 low", 1'b1, oe_sw1);
		chk_bit("sw2 idle", 1'b0, oe_sw2);
		u_dss_host.send({7'h7f, 14'h0123, 3'b100}, 24, 1'b1);
		rreg(`DSS_OFF_L2_REF);
		chk_word("l2 ref", 32'h123, d);
		rreg(`DSS_OFF_L1_REF);
		chk_word("l1 ref", 32'h8, d);
		chk_bit("sw2 low", 1'b1, oe_sw2);
		u_dss_host.send({4'h0, 10'h3ff, 7'h7f, 3'b011}, 20, 1'b0);
		rreg(`DSS_OFF_L1_NA);
		chk_word("l1 na kept", 32'h503, d);
		chk_bit("sw1 kept", 1'b1, oe_sw1);
		$display("load test done");
	endtask

	task automatic t_irq;
		rreg(`DSS_OFF_STATUS);
		chk_word("status", 32'h3, d & 32'h3);
		wreg(`DSS_OFF_MASK, 32'h1);
		repeat (2) @(posedge clk_sys);
		#1 chk_bit("irq on", 1'b1, irq);
		wreg(`DSS_OFF_STATUS, 32'h1);
		rreg(`DSS_OFF_STATUS);
		chk_word("status cleared", 32'h2, d & 32'h3);
		chk_bit("irq off", 1'b0, irq);
		wreg(`DSS_OFF_MASK, 32'h0);
		$display("irq test done");
	endtask

	task automatic t_count;
		logic dn;
		dn = 1'b0;
		hi = 0;
		for (k = 0; k < 42; k++) begin
			repeat (7) @(posedge clk_sys);
			#1;
			if (k >= 12 && mc1 === 1'b1) hi++;
			dn |= (oe_pd2 === 1'b1 && pd2 === 1'b0);
			@(posedge clk_sys);
			vco1 <= 1'b1;
			vco2 <= 1'b1;
			repeat (8) @(posedge clk_sys);
			vco1 <= 1'b0;
			vco2 <= 1'b0;
		end
		// The 30 sampled edges span three cycles of N=10, A=3, modulus high for 7 edges in each
		chk_word("mc1 high edges", 32'd21, hi);
		chk_bit("pd2 leading", 1'b1, dn);
		// Loop 2 keeps A at zero, so modulus goes high at the first reload and stays high
		#1 chk_bit("mc2 high", 1'b1, mc2);
		$display("counter test done");
	endtask

	task automatic t_lag;
		k = 0;
		while (k < 20000 && !(oe_pd2 === 1'b1 && pd2 === 1'b1)) begin
			@(posedge clk_sys);
			#1 k++;
		end
		if (k == 20000) begin
			$display("[ERR] pd2 lag expected 1 seen timeout");
			fail_count++;
		end else begin
			repeat (100) @(posedge clk_sys);
			#1 chk_bit("pd2 driven", 1'b1, oe_pd2);
			chk_bit("pd2 lagging", 1'b1, pd2);
			chk_bit("lock2 low", 1'b0, lock2);
		end
		$display("lag test done");
	endtask

	initial begin
		rst_n = 1'b0;
		{vco1, vco2, osc, wr, rd} = 5'h00;
		{addr, oc, wdata} = 40'h0;
		repeat (8) @(posedge clk_sys);
		rst_n <= 1'b1;
		t_load;
		t_irq;
		t_count;
		t_lag;
		wrap_up;
	end
endmodule
`default_nettype wire
